// [design/cmi_consts.svh]
/*
  Constants of the serial command block: opcodes, memory size, FIFO
  depths, event bit positions and the random generator seed.
  Included by the command block; defines only.
*/
`ifndef CMI_CONSTS_SVH
`define CMI_CONSTS_SVH

// opcode bits [7:1]; bit 0 is the priority of data-unit commands
`define CMI_OP_TXAPP   7'h1D
`define CMI_OP_RANDOM  7'h1E
`define CMI_OP_RXREAD  7'h15
`define CMI_OP_RXMOVE  7'h19
`define CMI_OP_TXCOPY  7'h1A
`define CMI_OP_BLKCOPY 7'h1B

`define CMI_MEM_DEPTH  1024
`define CMI_MEM_AW     10
`define CMI_MEM_LIMIT  13'h300
`define CMI_TXF_DEPTH  16
`define CMI_RXF_DEPTH  128
`define CMI_LFSR_SEED  16'hACE1

// event bits on exc_o
`define CMI_EXC_TX_OVR    0
`define CMI_EXC_RX_UNDER  1
`define CMI_EXC_STARVED   2
`define CMI_EXC_BAD_OP    3
`define CMI_EXC_SLOT_BUSY 4
`define CMI_EXC_DONE_L    5
`define CMI_EXC_DONE_H    6
`define CMI_EXC_BAD_ADDR  7

`endif

// [design/cmi_pkg.sv]
/*
  Types of the serial command block: command kinds, engine states and
  the queued data-unit job. Needs nothing from its surroundings.
*/
`default_nettype none
package cmi_pkg;

  typedef enum logic [6:0] {
    CMD_NONE    = 7'h01,
    CMD_TXAPP   = 7'h02,
    CMD_RANDOM  = 7'h04,
    CMD_RXREAD  = 7'h08,
    CMD_RXMOVE  = 7'h10,
    CMD_TXCOPY  = 7'h20,
    CMD_BLKCOPY = 7'h40
  } cmi_cmd_e;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CHECK = 5'h02,
    ST_RUN   = 5'h04,
    ST_RDW   = 5'h08,
    ST_DONE  = 5'h10
  } cmi_state_e;

  typedef struct packed {
    cmi_cmd_e    cmd;
    logic [7:0]  cnt;
    logic [11:0] src;
    logic [11:0] dst;
  } cmi_job_s;

endpackage : cmi_pkg
`default_nettype wire

// [design/cmi_fifo_if.sv]
/*
  Valid/ready FIFO carrier between the command block and its FIFOs.
  Assumes both ends run on the same clock.
*/
`default_nettype none
interface cmi_fifo_if #(
  parameter int W = 8
);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;
  logic [7:0]   count;

  modport fifo (input wdata, wvalid, rready, output wready, rdata, rvalid, count);
  modport user (output wdata, wvalid, rready, input wready, rdata, rvalid, count);
endinterface : cmi_fifo_if
`default_nettype wire

// [design/cmi_fifo.sv]
/*
  Synchronous FIFO with valid/ready on both sides and a fill count.
  Assumes a power-of-two depth of at most 128 and one clock.
*/
`default_nettype none
module cmi_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // both sides
  cmi_fifo_if.fifo  f
);
  localparam int AW = $clog2(D);
  localparam int CW = AW + 1;

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          nfull_q;
  logic          nempty_q;
  logic          push;
  logic          pop;

  assign push  = f.wvalid & nfull_q;
  assign pop   = f.rready & nempty_q;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= f.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_q     <= '0;
      rp_q     <= '0;
      cnt_q    <= '0;
      nfull_q  <= 1'h1;
      nempty_q <= 1'h0;
    end else begin
      wp_q     <= wp_q + AW'(push);
      rp_q     <= rp_q + AW'(pop);
      cnt_q    <= cnt_d;
      nfull_q  <= cnt_d != CW'(D);
      nempty_q <= cnt_d != '0;
    end
  end

  assign f.wready = nfull_q;
  assign f.rvalid = nempty_q;
  assign f.rdata  = mem_q[rp_q];
  assign f.count  = 8'(cnt_q);
endmodule : cmi_fifo
`default_nettype wire

// [design/cmi_ram.sv]
/*
  Byte RAM with one write port and one registered read port.
  Assumes a single clock; contents are not reset.
*/
`default_nettype none
module cmi_ram #(
  parameter int W = 8,
  parameter int D = 1024
) (
  // clock
  input  wire logic                 clk_i,
  // write port
  input  wire logic                 we_i,
  input  wire logic [$clog2(D)-1:0] waddr_i,
  input  wire logic [W-1:0]         wdata_i,
  // read port
  input  wire logic [$clog2(D)-1:0] raddr_i,
  output logic      [W-1:0]         rdata_o
);
  logic [W-1:0] mem_q [D];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : cmi_ram
`default_nettype wire

// [design/cmi_core.sv]
/*
  Serial command block: SPI instruction decode, transmit FIFO append,
  random bytes, receive FIFO read and a data-unit engine that moves
  bytes between the FIFOs and a local RAM.
  Assumes SPI mode 0 with a serial clock period of at least 8 clk_i
  cycles, and receiver and transmitter logic on clk_i.
*/
`default_nettype none
`include "cmi_consts.svh"
module cmi_core (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  // serial instruction port
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  // receive stream
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_valid_i,
  output logic            rx_ready_o,
  // transmit stream
  output logic [7:0]      tx_data_o,
  output logic            tx_valid_o,
  input  wire logic       tx_ready_i,
  // noise and control
  input  wire logic       noise_i,
  input  wire logic       rx_move_wait_on_empty_i,
  // events and status
  output logic [7:0]      exc_o,
  output logic [7:0]      remain_cnt_o
);
  cmi_pkg::cmi_cmd_e   cmd_q;
  cmi_pkg::cmi_cmd_e   cur_cmd;
  cmi_pkg::cmi_cmd_e   ecmd_q;
  cmi_pkg::cmi_state_e st_q;
  cmi_pkg::cmi_job_s   new_job;
  cmi_pkg::cmi_job_s   slot_job_q [2];
  logic [2:0]          sclk_sq;
  logic [2:0]          csn_sq;
  logic [1:0]          mosi_sq;
  logic [1:0]          noise_sq;
  logic [2:0]          bit_cnt_q;
  logic [7:0]          sh_in_q;
  logic [7:0]          sh_out_q;
  logic [7:0]          byte_q;
  logic                byte_v_q;
  logic [2:0]          idx_q;
  logic                prio_q;
  logic [7:0]          opb_q [1:3];
  logic                pop_pend_q;
  logic [15:0]         lfsr_q;
  logic [1:0]          slot_vld_q;
  logic                run_prio_q;
  logic [7:0]          ecnt_q;
  logic [11:0]         esrc_q;
  logic [11:0]         edst_q;
  logic [7:0]          remain_q;
  logic [7:0]          exc_d;
  logic [7:0]          exc_q;
  logic [7:0]          out_nxt;
  logic [7:0]          status;
  logic [7:0]          ram_rdata;
  logic                cs_act;
  logic                cs_start;
  logic                sclk_rise;
  logic                sclk_fall;
  logic                spi_push;
  logic                spi_pop;
  logic                issue_v;
  logic                eng_rx_pop;
  logic                eng_tx_push;
  logic                chk_op;
  logic                chk_addr;
  logic                starve;
  logic                tx_ovr_eng;
  logic                eng_done;
  logic                mem_we;
  logic [11:0]         mem_waddr;
  logic [7:0]          mem_wdata;

  function automatic cmi_pkg::cmi_cmd_e op_decode(input logic [6:0] op);
    cmi_pkg::cmi_cmd_e c;
    c = cmi_pkg::CMD_NONE;
    if (op == `CMI_OP_TXAPP) begin
      c = cmi_pkg::CMD_TXAPP;
    end else if (op == `CMI_OP_RANDOM) begin
      c = cmi_pkg::CMD_RANDOM;
    end else if (op == `CMI_OP_RXREAD) begin
      c = cmi_pkg::CMD_RXREAD;
    end else if (op == `CMI_OP_RXMOVE) begin
      c = cmi_pkg::CMD_RXMOVE;
    end else if (op == `CMI_OP_TXCOPY) begin
      c = cmi_pkg::CMD_TXCOPY;
    end else if (op == `CMI_OP_BLKCOPY) begin
      c = cmi_pkg::CMD_BLKCOPY;
    end
    return c;
  endfunction : op_decode

  // last byte of a block still below CMI_MEM_LIMIT (13'h300), not the whole 1024-byte RAM
  function automatic logic in_range(input logic [11:0] a, input logic [7:0] n);
    return ({1'h0, a} + {5'h00, n}) <= `CMI_MEM_LIMIT;
  endfunction : in_range

  cmi_fifo_if txf ();
  cmi_fifo_if rxf ();

  cmi_fifo #(.W(8), .D(`CMI_TXF_DEPTH)) u_txf (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .f        (txf)
  );

  cmi_fifo #(.W(8), .D(`CMI_RXF_DEPTH)) u_rxf (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .f        (rxf)
  );

  cmi_ram #(.W(8), .D(`CMI_MEM_DEPTH)) u_ram (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr[`CMI_MEM_AW-1:0]),
    .wdata_i (mem_wdata),
    .raddr_i (esrc_q[`CMI_MEM_AW-1:0]),
    .rdata_o (ram_rdata)
  );

  // pin synchronisers; bit 0 feeds only bit 1
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_sq  <= 3'h0;
      csn_sq   <= 3'h7;
      mosi_sq  <= 2'h0;
      noise_sq <= 2'h0;
    end else begin
      sclk_sq  <= {sclk_sq[1:0], spi_sclk_i};
      csn_sq   <= {csn_sq[1:0], spi_cs_n_i};
      mosi_sq  <= {mosi_sq[0], spi_mosi_i};
      noise_sq <= {noise_sq[0], noise_i};
    end
  end

  assign cs_act    = ~csn_sq[1];
  assign cs_start  = csn_sq[2] & ~csn_sq[1];
  assign sclk_rise = cs_act & sclk_sq[1] & ~sclk_sq[2];
  assign sclk_fall = cs_act & ~sclk_sq[1] & sclk_sq[2];

  // serial byte assembly
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt_q <= 3'h0;
      sh_in_q   <= 8'h00;
      byte_q    <= 8'h00;
      byte_v_q  <= 1'h0;
    end else begin
      byte_v_q <= 1'h0;
      if (!cs_act) begin
        bit_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        sh_in_q   <= {sh_in_q[6:0], mosi_sq[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          byte_q   <= {sh_in_q[6:0], mosi_sq[1]};
          byte_v_q <= 1'h1;
        end
      end
    end
  end

  // opcode and operand capture
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idx_q  <= 3'h0;
      cmd_q  <= cmi_pkg::CMD_NONE;
      prio_q <= 1'h0;
      opb_q  <= '{default: 8'h00};
    end else if (cs_start) begin
      idx_q <= 3'h0;
      cmd_q <= cmi_pkg::CMD_NONE;
    end else if (byte_v_q) begin
      if (idx_q != 3'h7) begin
        idx_q <= idx_q + 3'h1;
      end
      if (idx_q == 3'h0) begin
        cmd_q  <= cur_cmd;
        prio_q <= byte_q[0];
      end else if (idx_q <= 3'h3) begin
        opb_q[idx_q[1:0]] <= byte_q;
      end
    end
  end

  assign cur_cmd = (idx_q == 3'h0) ? op_decode(byte_q[7:1]) : cmd_q;
  assign status  = {slot_vld_q, st_q != cmi_pkg::ST_IDLE, ~txf.wready, ~rxf.rvalid, 3'h0};

  // byte to shift out during the next transfer
  always_comb begin
    out_nxt = 8'h00;
    case (cur_cmd)
      cmi_pkg::CMD_TXAPP:   out_nxt = txf.count + {7'h00, spi_push & txf.wready};
      cmi_pkg::CMD_RANDOM:  out_nxt = lfsr_q[7:0];
      cmi_pkg::CMD_RXREAD:  out_nxt = rxf.rvalid ? rxf.rdata : 8'h00;
      cmi_pkg::CMD_RXMOVE:  out_nxt = rxf.count;
      cmi_pkg::CMD_TXCOPY:  out_nxt = txf.count;
      default:              out_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_out_q <= 8'h00;
    end else if (cs_start) begin
      sh_out_q <= status;
    end else if (byte_v_q) begin
      sh_out_q <= out_nxt;
    end else if (sclk_fall && bit_cnt_q != 3'h0) begin
      sh_out_q <= {sh_out_q[6:0], 1'h0};
    end
  end

  assign spi_miso_o = sh_out_q[7];

  // receive byte leaves the FIFO once its transfer starts
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pop_pend_q <= 1'h0;
    end else if (!cs_act) begin
      pop_pend_q <= 1'h0;
    end else if (byte_v_q && cur_cmd == cmi_pkg::CMD_RXREAD) begin
      pop_pend_q <= rxf.rvalid;
    end else if (spi_pop) begin
      pop_pend_q <= 1'h0;
    end
  end

  assign spi_pop  = pop_pend_q & sclk_rise & (bit_cnt_q == 3'h0);
  assign spi_push = byte_v_q & (idx_q != 3'h0) & (cmd_q == cmi_pkg::CMD_TXAPP);

  // noise stirred into a shift register
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lfsr_q <= `CMI_LFSR_SEED;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10] ^ noise_sq[1]};
    end
  end

  // data-unit instruction complete after its last operand
  assign issue_v = byte_v_q & (((cmd_q == cmi_pkg::CMD_RXMOVE || cmd_q == cmi_pkg::CMD_TXCOPY) && idx_q == 3'h3)
                               || (cmd_q == cmi_pkg::CMD_BLKCOPY && idx_q == 3'h4));

  always_comb begin
    new_job.cmd = cmd_q;
    if (cmd_q == cmi_pkg::CMD_BLKCOPY) begin
      new_job.cnt = opb_q[1];
      new_job.src = {opb_q[2][7:4], opb_q[3]};
      new_job.dst = {opb_q[2][3:0], byte_q};
    end else begin
      new_job.cnt = byte_q;
      new_job.src = {opb_q[1][3:0], opb_q[2]};
      new_job.dst = 12'h000;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slot_vld_q <= 2'h0;
      slot_job_q <= '{default: '0};
    end else begin
      if (eng_done) begin
        slot_vld_q[run_prio_q] <= 1'h0;
      end
      if (issue_v && !slot_vld_q[prio_q]) begin
        slot_vld_q[prio_q] <= 1'h1;
        slot_job_q[prio_q] <= new_job;
      end
    end
  end

  assign chk_op      = (st_q == cmi_pkg::ST_CHECK) & (ecnt_q == 8'h00);
  assign chk_addr    = (st_q == cmi_pkg::ST_CHECK) & ~chk_op & (~in_range(esrc_q, ecnt_q)
                       | ((ecmd_q == cmi_pkg::CMD_BLKCOPY) & ~in_range(edst_q, ecnt_q)));
  // direct reads take the receive FIFO first
  assign eng_rx_pop  = (st_q == cmi_pkg::ST_RUN) & (ecmd_q == cmi_pkg::CMD_RXMOVE) & rxf.rvalid & ~spi_pop;
  assign starve      = (st_q == cmi_pkg::ST_RUN) & (ecmd_q == cmi_pkg::CMD_RXMOVE) & ~rxf.rvalid
                       & ~rx_move_wait_on_empty_i;
  assign tx_ovr_eng  = (st_q == cmi_pkg::ST_RDW) & (ecmd_q == cmi_pkg::CMD_TXCOPY) & ~txf.wready;
  assign eng_tx_push = (st_q == cmi_pkg::ST_RDW) & (ecmd_q == cmi_pkg::CMD_TXCOPY) & txf.wready & ~spi_push;
  assign eng_done    = st_q == cmi_pkg::ST_DONE;
  assign mem_we      = eng_rx_pop | ((st_q == cmi_pkg::ST_RDW) & (ecmd_q == cmi_pkg::CMD_BLKCOPY));
  assign mem_waddr   = (ecmd_q == cmi_pkg::CMD_RXMOVE) ? esrc_q : edst_q;
  assign mem_wdata   = (ecmd_q == cmi_pkg::CMD_RXMOVE) ? rxf.rdata : ram_rdata;

  assign txf.wvalid  = spi_push | eng_tx_push;
  assign txf.wdata   = spi_push ? byte_q : ram_rdata;
  assign txf.rready  = tx_ready_i;
  assign rxf.wvalid  = rx_valid_i;
  assign rxf.wdata   = rx_data_i;
  assign rxf.rready  = spi_pop | eng_rx_pop;

  // data-unit engine, one job at a time, high slot first
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q       <= cmi_pkg::ST_IDLE;
      run_prio_q <= 1'h0;
      ecmd_q     <= cmi_pkg::CMD_NONE;
      ecnt_q     <= 8'h00;
      esrc_q     <= 12'h000;
      edst_q     <= 12'h000;
      remain_q   <= 8'h00;
    end else begin
      case (st_q)
        cmi_pkg::ST_IDLE: begin
          if (|slot_vld_q) begin
            run_prio_q <= slot_vld_q[1];
            ecmd_q     <= slot_job_q[slot_vld_q[1]].cmd;
            ecnt_q     <= slot_job_q[slot_vld_q[1]].cnt;
            esrc_q     <= slot_job_q[slot_vld_q[1]].src;
            edst_q     <= slot_job_q[slot_vld_q[1]].dst;
            st_q       <= cmi_pkg::ST_CHECK;
          end
        end
        cmi_pkg::ST_CHECK: begin
          remain_q <= (chk_op || chk_addr) ? ecnt_q : 8'h00;
          st_q     <= (chk_op || chk_addr) ? cmi_pkg::ST_DONE : cmi_pkg::ST_RUN;
        end
        cmi_pkg::ST_RUN: begin
          if (ecmd_q != cmi_pkg::CMD_RXMOVE) begin
            st_q <= cmi_pkg::ST_RDW;
          end else if (eng_rx_pop) begin
            esrc_q <= esrc_q + 12'h001;
            ecnt_q <= ecnt_q - 8'h01;
            if (ecnt_q == 8'h01) begin
              st_q <= cmi_pkg::ST_DONE;
            end
          end else if (starve) begin
            remain_q <= ecnt_q;
            st_q     <= cmi_pkg::ST_DONE;
          end
        end
        cmi_pkg::ST_RDW: begin
          if (tx_ovr_eng) begin
            remain_q <= ecnt_q;
            st_q     <= cmi_pkg::ST_DONE;
          end else if (eng_tx_push || ecmd_q == cmi_pkg::CMD_BLKCOPY) begin
            esrc_q <= esrc_q + 12'h001;
            edst_q <= edst_q + 12'h001;
            ecnt_q <= ecnt_q - 8'h01;
            st_q   <= (ecnt_q == 8'h01) ? cmi_pkg::ST_DONE : cmi_pkg::ST_RUN;
          end
        end
        cmi_pkg::ST_DONE: st_q <= cmi_pkg::ST_IDLE;
        default:          st_q <= cmi_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    exc_d = 8'h00;
    exc_d[`CMI_EXC_TX_OVR]    = (spi_push & ~txf.wready) | tx_ovr_eng;
    exc_d[`CMI_EXC_RX_UNDER]  = byte_v_q & (cur_cmd == cmi_pkg::CMD_RXREAD) & ~rxf.rvalid;
    exc_d[`CMI_EXC_STARVED]   = starve;
    exc_d[`CMI_EXC_BAD_OP]    = chk_op;
    exc_d[`CMI_EXC_SLOT_BUSY] = issue_v & slot_vld_q[prio_q];
    exc_d[`CMI_EXC_DONE_L]    = eng_done & ~run_prio_q;
    exc_d[`CMI_EXC_DONE_H]    = eng_done & run_prio_q;
    exc_d[`CMI_EXC_BAD_ADDR]  = chk_addr;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      exc_q <= 8'h00;
    end else begin
      exc_q <= exc_d;
    end
  end

  assign exc_o        = exc_q;
  assign remain_cnt_o = remain_q;
  assign rx_ready_o   = rxf.wready;
  assign tx_valid_o   = txf.rvalid;
  assign tx_data_o    = txf.rdata;
endmodule : cmi_core
`default_nettype wire

// [verification/cmi_core_checker.sv]
/*
  Checker of the command block's stream and event ports.
  Assumes it is bound to the block's top module.
*/
`default_nettype none
module cmi_core_checker (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  // watched ports
  input wire logic       tx_ready_i,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       rx_move_wait_on_empty_i,
  input wire logic [7:0] exc_o,
  input wire logic [7:0] remain_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  sequence done_s;
    ##[0:4] (exc_o[5] || exc_o[6]);
  endsequence
  lo_done_pulse_a: assert property (exc_o[5] |=> !exc_o[5])
    else $error("low done held");
  hi_done_pulse_a: assert property ($rose(exc_o[6]) |=> $fell(exc_o[6]))
    else $error("high done held");
  bad_op_done_a: assert property (exc_o[3] |-> done_s)
    else $error("bad operand without done");
  bad_addr_done_a: assert property (exc_o[7] |-> done_s)
    else $error("bad address without done");
  starve_nowait_a: assert property (exc_o[2] |-> !$past(rx_move_wait_on_empty_i))
    else $error("starved while waiting");
  starve_remain_a: assert property (exc_o[2] |-> ##[0:3] (remain_cnt_o != 8'h00))
    else $error("starved with nothing left");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("head lost while stalled");
  tx_ovr_full_a: assert property (exc_o[0] |-> $past(tx_valid_o))
    else $error("overrun while not full");
  cover property (exc_o[6]);
  cover property (exc_o[2]);
  cover property (exc_o[0] ##[1:40] exc_o[5]);
endmodule : cmi_core_checker

bind cmi_core cmi_core_checker i_chk (
  .clk_i,
  .arst_n_i,
  .tx_ready_i,
  .tx_valid_o,
  .tx_data_o,
  .rx_move_wait_on_empty_i,
  .exc_o,
  .remain_cnt_o
);
`default_nettype wire

// [verification/cmi_spi_host.sv]
/*
  Host model of the serial link: mode 0 byte frames, 160 ns clock.
  Assumes the bench calls its tasks one at a time.
*/
`default_nettype none
module cmi_spi_host (
  // serial link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock idles low outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic start();
    cs_n_o = 1'b0;
    #160;
  endtask : start
  // data set while clock low, answer taken at rise
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = d[i];
      #80 sclk_o = 1'b1;
      r[i] = miso_i;
      #80 sclk_o = 1'b0;
    end
    #160;
  endtask : xfer
  // released data line shows the inverse
  task automatic stop();
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #320;
  endtask : stop
endmodule : cmi_spi_host
`default_nettype wire

// [verification/tb_cmi_core.sv]
/*
  Bench of the command block: host model on the link, byte streams
  on both FIFO sides, events gathered in a sticky mask.
  Assumes design, checker and host model are compiled first.
*/
`default_nettype none
module tb_cmi_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i    = 1'b0;
  logic       arst_n_i = 1'b0;
  logic       rx_valid = 1'b0;
  logic       tx_ready = 1'b0;
  logic       noise    = 1'b0;
  logic       wait_e   = 1'b0;
  logic       drain_en = 1'b0;
  logic [7:0] rx_data  = 8'h00;
  logic [7:0] seen_q   = 8'h00;
  logic       sclk, cs_n, mosi, miso, rx_ready, tx_valid;
  logic [7:0] tx_data, exc, remain;
  logic [7:0] txq[$], rq[$], mv[$];
  int         miscompares = 0;
  int         checks_done = 0;
  int         cyc = 0;
  cmi_spi_host i_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  cmi_core i_dut (
    .clk_i, .arst_n_i, .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tx_data_o(tx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .noise_i(noise), .rx_move_wait_on_empty_i(wait_e),
    .exc_o(exc), .remain_cnt_o(remain)
  );
  always #10 clk_i = ~clk_i;
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // stream monitor pops the oldest note
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    seen_q <= seen_q | exc;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      check("tx_data", tx_data, txq.size() > 0 ? txq.pop_front() : 8'hXX);
    end
    #2;
    noise = 1'($urandom);
    tx_ready = drain_en & 1'($urandom);
  end
  always @(posedge clk_i) begin
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic clr();
    @(posedge clk_i);
    #2 seen_q = 8'h00;
  endtask : clr
  task automatic frame(input logic [7:0] d[$]);
    logic [7:0] r;
    rq = {};
    i_host.start();
    foreach (d[k]) begin
      i_host.xfer(d[k], r);
      rq.push_back(r);
    end
    i_host.stop();
  endtask : frame
  task automatic rx_put(input logic [7:0] v);
    @(posedge clk_i);
    #2 rx_valid = 1'b1;
    rx_data = v;
    do @(posedge clk_i); while (rx_ready !== 1'b1);
    #2 rx_valid = 1'b0;
  endtask : rx_put
  task automatic drain();
    drain_en = 1'b1;
    for (int k = 0; k < 500 && txq.size() > 0; k++) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
    #2 drain_en = 1'b0;
    check("left", 8'(txq.size()), 8'h00);
  endtask : drain
  initial begin
    logic [7:0]  v[$];
    logic [55:0] row[5];
    void'($urandom(32'h48D9D3A3));
    row = '{56'h32008003002402, 56'h32008000002800, 56'h3502FF0200C002,
            56'h36020140002000, 56'h34010002002000};
    repeat (16) @(posedge clk_i);
    #2 arst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    check("rx_ready", 8'(rx_ready), 8'h01);
    v = {8'h3A};
    for (int k = 0; k < 17; k++) v.push_back(8'($urandom));
    txq = v[1:16];
    clr();
    frame(v);
    for (int k = 1; k < 18; k++) check("count", rq[k], 8'(k - 1));
    check("events", seen_q, 8'h01);
    drain();
    $display("test append finished");
    // direct reads only while no move runs
    v = {8'($urandom), 8'($urandom)};
    rx_put(v[0]);
    rx_put(v[1]);
    clr();
    frame({8'h2A, 8'h00, 8'h00, 8'h00});
    check("rx_read", rq[1], v[0]);
    check("rx_read", rq[2], v[1]);
    check("events", seen_q, 8'h02);
    $display("test read finished");
    wait_e = 1'b1;
    clr();
    frame({8'h33, 8'h00, 8'h40, 8'h03});
    frame({8'h33, 8'h00, 8'h80, 8'h01});
    check("status", rq[0], 8'hA8);
    frame({8'h34, 8'h00, 8'h40, 8'h03});
    repeat (40) @(posedge clk_i);
    check("events", seen_q, 8'h10);
    for (int k = 0; k < 3; k++) begin
      mv.push_back(8'($urandom));
      txq.push_back(mv[k]);
      rx_put(mv[k]);
    end
    repeat (40) @(posedge clk_i);
    drain();
    check("events", seen_q, 8'h70);
    $display("test move finished");
    v = {8'h3A};
    for (int k = 0; k < 15; k++) v.push_back(8'($urandom));
    txq = {v[1:15], mv[0]};
    clr();
    frame(v);
    frame({8'h34, 8'h00, 8'h40, 8'h03});
    check("count", rq[3], 8'h0F);
    repeat (30) @(posedge clk_i);
    check("events", seen_q, 8'h21);
    check("remain", remain, 8'h02);
    drain();
    $display("test overrun finished");
    wait_e = 1'b0;
    rx_put(8'h5A);
    txq = {mv[0], mv[1]};
    foreach (row[i]) begin
      clr();
      frame({row[i][55:48], row[i][47:40], row[i][39:32], row[i][31:24], row[i][23:16]});
      repeat (30) @(posedge clk_i);
      check("events", seen_q, row[i][15:8]);
      check("remain", remain, row[i][7:0]);
    end
    drain();
    $display("test table finished");
    frame({8'h3C, 8'h00, 8'h00, 8'h00});
    check("random", 8'(rq[1] === rq[2] && rq[2] === rq[3]), 8'h00);
    $display("test random finished");
    test_done();
  end
endmodule : tb_cmi_core
`default_nettype wire
